// ### common/rst_seq_cfg.svh
// Constants for the reset entry and pin state logic
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH
`define MIN_LOW_CYCLES 5'd20
`define LOW_CNT_W 5
`define RESET_VECTOR_ADDR 20'hffffc
`define ADDR_W 20
`define DATA_W 8
`define FETCH_BYTES 2'd3
`define LOW_PORT_ALL_IN 8'hff
`define PORT4_PULLUPS 3'h7
`endif

// ### common/rst_seq_pkg.sv
// Types for the reset entry and pin state logic
package rst_seq_pkg;
    typedef enum logic [2:0]
    {
        ST_RUN = 3'b000,
        ST_HELD = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT = 3'b011,
        ST_GO = 3'b100
    } seq_state_t;
endpackage

// ### common/vec_fetch_if.sv
// Vector fetch request and answer between sequencer and fetch unit
`timescale 1ns/1ps
interface vec_fetch_if;
    logic start;
    logic busy;
    logic done;
    logic [19:0] vector;
    modport seq
    (
        output start,
        input busy,
        input done,
        input vector
    );
    modport fetch
    (
        input start,
        output busy,
        output done,
        output vector
    );
endinterface

// ### core/reset_pin_control.sv
// Reset pin filter, reset sequencer and pin state control during reset
// How it works
// [R1] Hardware and software reset share one exit
// [R2] Reset pin held low twenty clocks
// [R3] On release, start from reset vector
// [R4] Pin released only with stable clock
// [R5] Boot pin low: all pins float
// [R6] Boot pin high: chip select high
// [R7] Boot pin high: write, read strobes high
// [R8] Boot pin high, sixteen-bit bus: address latch low
// [R9] Bus grant follows hold request
// [R10] Other bus pins per boot mode
// [R11] Vectors fetched from top of space
// [R12] Synchronise pin, count low samples
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module reset_pin_control
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic resetPin_n,
    input wire logic softReset,
    input wire logic boot_mode_pin,
    input wire logic busWidth8,
    input wire logic holdRequest_n,
    output logic [`ADDR_W-1:0] memAddr,
    output logic memRead,
    input wire logic [`DATA_W-1:0] memData,
    output logic inReset,
    output logic cpuRun,
    output logic [`ADDR_W-1:0] startPc,
    output logic [7:0] low_data_port_oe_n,
    output logic [7:0] high_data_port_oe_n,
    output logic addressOe_n,
    output logic chip_select_zero_n,
    output logic chip_select_zero_oe_n,
    output logic writeStrobe_n,
    output logic readStrobe_n,
    output logic strobeOe_n,
    output logic upper_byte_enable_oe_n,
    output logic busClockOe_n,
    output logic bus_grant_ack,
    output logic bus_grant_ack_oe_n,
    output logic addrLatch,
    output logic addrLatchOe_n,
    output logic [2:0] port4PullUp
);
    // ************************************
    // Input synchronisers
    // ************************************
    logic pinMeta, pinSync, bootMeta, bootSync, widthMeta, widthSync, holdMeta, holdSync;
    always_ff @(posedge clk)
    begin
        pinMeta <= resetPin_n; // see [R12]
        pinSync <= pinMeta;
        bootMeta <= boot_mode_pin;
        bootSync <= bootMeta;
        widthMeta <= busWidth8;
        widthSync <= widthMeta;
        holdMeta <= holdRequest_n;
        holdSync <= holdMeta;
    end

    // ************************************
    // Low duration filter
    // ************************************
    logic [`LOW_CNT_W-1:0] lowCount;
    logic lowLongEnough;
    assign lowLongEnough = (lowCount >= `MIN_LOW_CYCLES); // see [R2]

    always_ff @(posedge clk)
    begin
        if (!reset_n || pinSync)
            lowCount <= 5'd0;
        else if (!lowLongEnough)
            lowCount <= lowCount + 5'd1; // see [R12]
    end

    // ************************************
    // Sequencer
    // ************************************
    vec_fetch_if fetchBus();
    seq_state_t state, next_state;
    logic startReg;
    logic enterReset;
    // Short low glitches on the pin never put the sequencer into reset
    assign enterReset = lowLongEnough || softReset; // see [R1]
    assign fetchBus.start = startReg;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN: if (enterReset) next_state = ST_HELD;
            // Release trusted only because the pin owner waited for clock
            ST_HELD: if (pinSync && !softReset) next_state = ST_FETCH; // see [R3] see [R4]
            ST_FETCH: next_state = ST_WAIT;
            ST_WAIT: if (fetchBus.done) next_state = ST_GO;
            ST_GO: next_state = ST_RUN;
            default: next_state = ST_HELD;
        endcase
        if (enterReset)
            next_state = ST_HELD;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= ST_HELD;
            startReg <= 1'b0;
            inReset <= 1'b1;
            cpuRun <= 1'b0;
            startPc <= 20'h00000;
        end
        else
        begin
            state <= next_state;
            startReg <= (next_state == ST_FETCH);
            inReset <= (next_state == ST_HELD);
            if (state == ST_WAIT && fetchBus.done)
                startPc <= fetchBus.vector; // see [R3]
            cpuRun <= (next_state == ST_RUN) || (next_state == ST_GO); // see [R1]
        end
    end

    vector_fetch fetchUnit
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(fetchBus.fetch),
        .memAddr(memAddr),
        .memRead(memRead),
        .memData(memData)
    );

    // ************************************
    // Pin states while held in reset
    // ************************************
    logic heldBus, heldFloat, wide;
    assign heldBus = (next_state == ST_HELD) && bootSync;
    assign heldFloat = (next_state == ST_HELD) && !bootSync; // see [R5]
    assign wide = !widthSync;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            low_data_port_oe_n <= `LOW_PORT_ALL_IN;
            high_data_port_oe_n <= `LOW_PORT_ALL_IN;
            addressOe_n <= 1'b1;
            chip_select_zero_n <= 1'b1;
            chip_select_zero_oe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            readStrobe_n <= 1'b1;
            strobeOe_n <= 1'b1;
            upper_byte_enable_oe_n <= 1'b1;
            busClockOe_n <= 1'b1;
            bus_grant_ack <= 1'b0;
            bus_grant_ack_oe_n <= 1'b1;
            addrLatch <= 1'b0;
            addrLatchOe_n <= 1'b1;
            port4PullUp <= 3'h0;
        end
        else
        begin
            // Data ports float in every reset case; run time owns them later
            low_data_port_oe_n <= `LOW_PORT_ALL_IN; // see [R10]
            high_data_port_oe_n <= `LOW_PORT_ALL_IN; // see [R10]
            addressOe_n <= !heldBus; // see [R5] see [R10]
            chip_select_zero_n <= 1'b1; // see [R6]
            chip_select_zero_oe_n <= !heldBus; // see [R6]
            writeStrobe_n <= 1'b1; // see [R7]
            readStrobe_n <= 1'b1;
            strobeOe_n <= !heldBus; // see [R7]
            upper_byte_enable_oe_n <= !heldBus; // see [R10]
            busClockOe_n <= !heldBus; // see [R10]
            bus_grant_ack <= !holdSync; // see [R9]
            bus_grant_ack_oe_n <= !heldBus; // see [R9]
            addrLatch <= 1'b0; // see [R8]
            addrLatchOe_n <= !(heldBus && wide); // see [R8]
            port4PullUp <= heldBus ? `PORT4_PULLUPS : 3'h0; // see [R10]
        end
    end

    // ************************************
    // Checks
    // ************************************
    float_all_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R5]
        (state == ST_HELD && !bootSync && $past(state) == ST_HELD)
        |-> (addressOe_n && strobeOe_n && chip_select_zero_oe_n && bus_grant_ack_oe_n))
        else $error("pin driven in float reset");
    cs_inactive_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R6]
        !chip_select_zero_oe_n |-> chip_select_zero_n)
        else $error("chip select low in reset");
    strobes_high_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R7]
        !strobeOe_n |-> (writeStrobe_n && readStrobe_n))
        else $error("strobe active in reset");
    latch_low_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R8]
        (heldBus && wide) |=> (!addrLatchOe_n && !addrLatch))
        else $error("address latch not low");
    grant_follow_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R9]
        heldBus |=> (bus_grant_ack == !$past(holdSync)))
        else $error("grant does not follow hold");
    min_low_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R2]
        (state == ST_RUN && !softReset && !pinSync && lowCount < `MIN_LOW_CYCLES)
        |=> state != ST_HELD)
        else $error("reset entered too early");
    vector_used_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R3]
        (state == ST_FETCH) |-> ##[1:6] (state == ST_GO && startPc == fetchBus.vector))
        else $error("start address not from vector");
    soft_same_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R1]
        (state == ST_RUN && softReset) |=> (state == ST_HELD && inReset))
        else $error("soft reset path differs");
    pullup_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R10]
        heldBus |=> port4PullUp == `PORT4_PULLUPS)
        else $error("pull-ups missing");
    cs_driven_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R6]
        heldBus |=> (!chip_select_zero_oe_n && chip_select_zero_n))
        else $error("chip select not driven high");
    strobe_driven_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R7]
        heldBus |=> (!strobeOe_n && writeStrobe_n && readStrobe_n))
        else $error("strobes not driven high");
    count_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R12]
        pinSync |=> (lowCount == '0))
        else $error("low count not cleared");
    run_start_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R3]
        (state == ST_GO) |-> (cpuRun && !inReset))
        else $error("core not running after fetch");
    top_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R11]
        memRead |-> (memAddr >= `RESET_VECTOR_ADDR))
        else $error("vector read outside top region");
endmodule

// ### core/vector_fetch.sv
// Reads the three reset vector bytes from the top of the address space
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module vector_fetch
(
    input wire logic clk,
    input wire logic reset_n,
    vec_fetch_if.fetch port,
    output logic [`ADDR_W-1:0] memAddr,
    output logic memRead,
    input wire logic [`DATA_W-1:0] memData
);
    logic [1:0] byteIdx;
    logic [`ADDR_W-1:0] vec;
    logic active;
    logic doneReg;
    logic [`ADDR_W-1:0] next_vec;
    logic [`ADDR_W-1:0] addrReg;

    // Byte order is low, middle, then the top nibble
    assign next_vec = (byteIdx == 2'd0) ? {vec[19:8], memData}
        : (byteIdx == 2'd1) ? {vec[19:16], memData, vec[7:0]}
        : {memData[3:0], vec[15:0]};
    // Address is a flop so the pin never glitches while the index moves
    assign memAddr = addrReg; // see [R11]
    assign memRead = active;
    assign port.busy = active;
    assign port.done = doneReg;
    assign port.vector = vec;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            byteIdx <= 2'd0;
            vec <= 20'h00000;
            active <= 1'b0;
            doneReg <= 1'b0;
            addrReg <= `RESET_VECTOR_ADDR;
        end
        else
        begin
            doneReg <= 1'b0;
            if (port.start && !active)
            begin
                active <= 1'b1;
                byteIdx <= 2'd0;
                addrReg <= `RESET_VECTOR_ADDR; // see [R11]
            end
            else if (active)
            begin
                vec <= next_vec; // see [R11]
                byteIdx <= byteIdx + 2'd1;
                addrReg <= addrReg + 20'h00001;
                if (byteIdx == `FETCH_BYTES - 2'd1)
                begin
                    active <= 1'b0;
                    doneReg <= 1'b1;
                end
            end
        end
    end
endmodule

// ### tb/tb_hardware_reset_pin_state_control.sv
// Self-checking bench for reset entry, vector start and pin states
`timescale 1ns/1ps
module tb_hardware_reset_pin_state_control;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic resetPin_n = 1'b1;
    logic softReset = 1'b0;
    logic boot_mode_pin = 1'b0;
    logic busWidth8 = 1'b1;
    logic holdRequest_n = 1'b1;
    int heldCycles = 0;
    logic [19:0] memAddr, startPc;
    logic [7:0] memData, low_data_port_oe_n, high_data_port_oe_n;
    logic [2:0] port4PullUp;
    logic memRead, inReset, cpuRun, addressOe_n, chip_select_zero_n, chip_select_zero_oe_n;
    logic writeStrobe_n, readStrobe_n, strobeOe_n, upper_byte_enable_oe_n, busClockOe_n;
    logic bus_grant_ack, bus_grant_ack_oe_n, addrLatch, addrLatchOe_n;
    int nFail = 0;
    int checkCount = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (inReset === 1'b1)
            heldCycles <= heldCycles + 1;
    end
    reset_pin_control reset_pin_control_i (.clk, .reset_n, .resetPin_n, .softReset,
        .boot_mode_pin, .busWidth8, .holdRequest_n, .memAddr, .memRead, .memData, .inReset,
        .cpuRun, .startPc, .low_data_port_oe_n, .high_data_port_oe_n, .addressOe_n,
        .chip_select_zero_n, .chip_select_zero_oe_n, .writeStrobe_n, .readStrobe_n,
        .strobeOe_n, .upper_byte_enable_oe_n, .busClockOe_n, .bus_grant_ack,
        .bus_grant_ack_oe_n, .addrLatch, .addrLatchOe_n, .port4PullUp);
    vector_rom_model vector_rom_model_i (.clk, .memAddr, .memRead, .memData);
    // ****************
    // Shared tasks
    // ****************
    task check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nFail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for the core to start running from the vector
    task wait_run;
        int i;
        i = 0;
        while (cpuRun !== 1'b1 && i < 100)
        begin
            cycles(1);
            i++;
        end
        if (cpuRun !== 1'b1)
        begin
            nFail++;
            $display("wrong value cpuRun expected 1 seen %b", cpuRun);
        end
        else
            check("startPc", startPc, 20'h51234);
    endtask
    task hold_pin(input int n);
        resetPin_n = 1'b0;
        cycles(n);
        resetPin_n = 1'b1;
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_boot;
        wait_run();
        check("inReset", 20'(inReset), 20'h0);
        $display("test boot done");
    endtask
    // One cycle short must be ignored, the exact minimum must take
    task t_filter;
        int base;
        base = heldCycles;
        hold_pin(19);
        cycles(6);
        check("shortPulse", 20'(heldCycles != base), 20'h0);
        base = heldCycles;
        hold_pin(20);
        cycles(6);
        check("minPulse", 20'(heldCycles != base), 20'h1);
        wait_run();
        $display("test filter done");
    endtask
    task t_pins(input logic boot, input logic w8);
        boot_mode_pin = boot;
        busWidth8 = w8;
        holdRequest_n = 1'b0;
        resetPin_n = 1'b0;
        cycles(30);
        check("lowOe", 20'(low_data_port_oe_n), 20'hff);
        check("highOe", 20'(high_data_port_oe_n), 20'hff);
        if (boot)
        begin
            check("cs", 20'({chip_select_zero_n, chip_select_zero_oe_n}), 20'h2);
            check("strobes", 20'({writeStrobe_n, readStrobe_n, strobeOe_n}), 20'h6);
            check("ale", 20'({addrLatch, addrLatchOe_n}), 20'(w8));
            check("grant", 20'({bus_grant_ack, bus_grant_ack_oe_n}), 20'h2);
            holdRequest_n = 1'b1;
            cycles(4);
            check("grantOff", 20'(bus_grant_ack), 20'h0);
            check("addrOe", 20'(addressOe_n), 20'h0);
            check("ubeClkOe", 20'({upper_byte_enable_oe_n, busClockOe_n}), 20'h0);
            check("pullUps", 20'(port4PullUp), 20'h7);
        end
        else
        begin
            check("allOe", 20'({addressOe_n, chip_select_zero_oe_n, strobeOe_n,
                upper_byte_enable_oe_n, busClockOe_n, bus_grant_ack_oe_n, addrLatchOe_n}),
                20'h7f);
            check("pullUpsOff", 20'(port4PullUp), 20'h0);
        end
        resetPin_n = 1'b1;
        wait_run();
        $display("test pins done");
    endtask
    task t_soft;
        softReset = 1'b1;
        cycles(3);
        check("softHeld", 20'(inReset), 20'h1);
        softReset = 1'b0;
        wait_run();
        $display("test soft done");
    endtask
    initial
    begin
        cycles(2);
        reset_n = 1'b1;
        t_boot();
        t_filter();
        t_pins(1'b0, 1'b1);
        t_pins(1'b1, 1'b1);
        t_pins(1'b1, 1'b0);
        t_soft();
        close_out();
    end
endmodule

// ### tb/vector_rom_model.sv
// Model of the memory that answers the reset vector reads
`timescale 1ns/1ps
module vector_rom_model
(
    input wire logic clk,
    input wire logic [19:0] memAddr,
    input wire logic memRead,
    output logic [7:0] memData
);
    logic [7:0] lastByte;
    logic [7:0] romByte;
    // Top byte upper nibble is junk so a wrong slice shows
    assign romByte = (memAddr == 20'hffffc) ? 8'h34 : (memAddr == 20'hffffd) ? 8'h12 :
        (memAddr == 20'hffffe) ? 8'ha5 : 8'h5a;
    // Idle bus shows the inverse of the last byte, never a stale copy
    assign memData = memRead ? romByte : ~lastByte;
    always @(posedge clk)
    begin
        if (memRead)
            lastByte <= romByte;
    end
endmodule
